// ### hdl/cell_prot_pkg.sv
package cell_prot_pkg;

  // ---------------------------------------------------------------
  // Timing figures
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS              = 10;
  // Typical release delay of the overcurrent state, in microseconds
  localparam int unsigned OVERCURRENT_RELEASE_US     = 9000;
  localparam int unsigned OVERCURRENT_RELEASE_CYCLES =
    (OVERCURRENT_RELEASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Delays that are option codes; plain defaults in microseconds
  localparam int unsigned OVERCHARGE_DETECT_US       = 1000;
  localparam int unsigned OVERCHARGE_RELEASE_US      = 1000;
  localparam int unsigned OVERDISCHARGE_DETECT_US    = 1000;
  localparam int unsigned OVERDISCHARGE_RELEASE_US   = 1000;
  localparam int unsigned OVERCURRENT_ONE_US         = 1000;
  localparam int unsigned OVERCURRENT_TWO_US         = 100;
  localparam int unsigned OVERCHARGE_DETECT_CYCLES   =
    (OVERCHARGE_DETECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OVERCHARGE_RELEASE_CYCLES  =
    (OVERCHARGE_RELEASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OVERDISCHARGE_DETECT_CYCLES =
    (OVERDISCHARGE_DETECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OVERDISCHARGE_RELEASE_CYCLES =
    (OVERDISCHARGE_RELEASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OVERCURRENT_ONE_CYCLES     =
    (OVERCURRENT_ONE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OVERCURRENT_TWO_CYCLES     =
    (OVERCURRENT_TWO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned TIMER_WIDTH = 24;
  localparam logic [TIMER_WIDTH-1:0] TIMER_RESET = 24'h000000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OC_AUTO_ONE = 2'b00,
    OC_AUTO_TWO = 2'b01,
    OC_LATCH    = 2'b10
  } oc_release_t;

  // Comparator results, raw; the state logic synchronises them
  typedef struct packed {
    logic above_overcharge_detect;    // Cell above overcharge_detect_level
    logic below_overcharge_release;   // Cell below overcharge_release_level
    logic below_overdischarge_detect; // Cell below overdischarge_detect_level
    logic above_overdischarge_release;// Cell above overdischarge_release_level
    logic sense_above_charger_release;// Sense node above charger_release_level
    logic sense_above_charger_detect; // Sense node above charger_detect_level
    logic sense_below_oc_release;     // Sense node below overcurrent_release_level
    logic above_oc_one;               // Shunt above overcurrent_level_one
    logic above_oc_two;               // Shunt above overcurrent_level_two
  } compare_t;

  // Option straps
  typedef struct packed {
    logic        overcharge_latch;
    logic        overdischarge_latch;
    logic        oc_two_enable;
    oc_release_t oc_release;
  } options_t;

  // Gate and sense-node drive
  typedef struct packed {
    logic charge_gate;
    logic discharge_gate;
    logic sense_pulldown;
    logic sense_pullup;
    logic standby;
  } drive_t;

endpackage

// ### hdl/hold_timer.sv
`timescale 1ns/1ns
// Counts while a condition holds; fires once it has held the full delay.
module hold_timer #(
  parameter int unsigned WIDTH = 24
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  // Condition and delay
  input  wire logic             cond_in,
  input  wire logic [WIDTH-1:0] delay_in,
  // Result
  output logic                  expired_out
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             expired;
  } timer_state_t;

  timer_state_t state;
  timer_state_t next_state;

  // Restart from zero as soon as the condition drops
  always_comb
  begin
    next_state = state;
    if (!cond_in)
    begin
      next_state.count   = '0;
      next_state.expired = 1'b0;
    end
    else if (state.count + WIDTH'(1) >= delay_in)
    begin
      next_state.expired = 1'b1;
    end
    else
    begin
      next_state.count = state.count + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign expired_out = state.expired;

endmodule

// ### hdl/cell_protection_state_logic.sv
`timescale 1ns/1ns
module cell_protection_state_logic #(
  parameter int unsigned WIDTH                  = cell_prot_pkg::TIMER_WIDTH,
  parameter int unsigned OVERCHARGE_DETECT      = cell_prot_pkg::OVERCHARGE_DETECT_CYCLES,
  parameter int unsigned OVERCHARGE_RELEASE     = cell_prot_pkg::OVERCHARGE_RELEASE_CYCLES,
  parameter int unsigned OVERDISCHARGE_DETECT   = cell_prot_pkg::OVERDISCHARGE_DETECT_CYCLES,
  parameter int unsigned OVERDISCHARGE_RELEASE  = cell_prot_pkg::OVERDISCHARGE_RELEASE_CYCLES,
  parameter int unsigned OVERCURRENT_ONE        = cell_prot_pkg::OVERCURRENT_ONE_CYCLES,
  parameter int unsigned OVERCURRENT_TWO        = cell_prot_pkg::OVERCURRENT_TWO_CYCLES,
  parameter int unsigned OVERCURRENT_RELEASE    = cell_prot_pkg::OVERCURRENT_RELEASE_CYCLES
) (
  // Clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    nrst_in,
  // Comparator results from the analog front end
  input  wire cell_prot_pkg::compare_t compare_in,
  // Option straps, static in use
  input  wire cell_prot_pkg::options_t options_in,
  // Gate and sense-node drive
  output logic                         charge_gate_out,
  output logic                         discharge_gate_out,
  output logic                         sense_pulldown_out,
  output logic                         sense_pullup_out,
  output logic                         standby_out,
  // State flags
  output logic                         overcharge_out,
  output logic                         overdischarge_out,
  output logic                         overcurrent_out
);

  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DIS_NORMAL   = 2'b00,
    DIS_OVERDIS  = 2'b01,
    DIS_STANDBY  = 2'b10,
    DIS_OVERCUR  = 2'b11
  } dis_state_t;

  typedef struct packed {
    // Synchroniser stages
    cell_prot_pkg::compare_t meta;
    cell_prot_pkg::compare_t cmp;
    cell_prot_pkg::options_t opt_meta;
    cell_prot_pkg::options_t opt;
    // Fault states and registered drive
    logic                    overcharge;
    dis_state_t              dis;
    cell_prot_pkg::drive_t   drive;
    logic                    overcharge_flag;
    logic                    overdischarge_flag;
    logic                    overcurrent_flag;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  // Timer conditions
  logic oc_detect_cond;
  logic oc_release_cond;
  logic od_detect_cond;
  logic od_release_cond;
  logic cur_one_cond;
  logic cur_two_cond;
  logic cur_release_cond;

  // Timer expiry
  logic oc_detect_done;
  logic oc_release_done;
  logic od_detect_done;
  logic od_release_done;
  logic cur_one_done;
  logic cur_two_done;
  logic cur_release_done;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Delay figure at timer width
  function automatic logic [WIDTH-1:0] to_delay(input int unsigned cycles);
    to_delay = WIDTH'(cycles);
  endfunction

  // Both overdischarge states share release and flag
  function automatic logic is_overdischarged(input dis_state_t dis);
    is_overdischarged = (dis == DIS_OVERDIS) || (dis == DIS_STANDBY);
  endfunction

  // Latched overcurrent release waits for a charger
  function automatic logic oc_latched(input cell_prot_pkg::options_t opt);
    oc_latched = (opt.oc_release == cell_prot_pkg::OC_LATCH);
  endfunction

  // ---------------------------------------------------------------
  // Timer conditions
  // ---------------------------------------------------------------
  // Conditions read only the second synchroniser stage
  always_comb
  begin
    // Detect timer idles while overcharged
    oc_detect_cond  = !state.overcharge && state.cmp.above_overcharge_detect;
    // Latched release accepts only the charger-removed combination
    oc_release_cond = state.overcharge &&
                      ((state.cmp.sense_above_charger_release && !state.cmp.above_overcharge_detect) ||
                       (!state.opt.overcharge_latch && !state.cmp.sense_above_charger_release &&
                        state.cmp.below_overcharge_release));

    // Discharge faults are only detected from the normal state
    od_detect_cond  = (state.dis == DIS_NORMAL) && state.cmp.below_overdischarge_detect;
    // Release is also counted from standby
    od_release_cond = is_overdischarged(state.dis) &&
                      ((!state.cmp.sense_above_charger_detect && !state.cmp.below_overdischarge_detect) ||
                       (!state.opt.overdischarge_latch && state.cmp.sense_above_charger_detect &&
                        state.cmp.above_overdischarge_release));

    // Two overcurrent levels, each with its own delay
    cur_one_cond    = (state.dis == DIS_NORMAL) && state.cmp.above_oc_one;
    cur_two_cond    = (state.dis == DIS_NORMAL) && state.opt.oc_two_enable &&
                      state.cmp.above_oc_two;
    // Same node level for all release options; only the pull differs
    cur_release_cond = (state.dis == DIS_OVERCUR) && state.cmp.sense_below_oc_release;
  end

  // ---------------------------------------------------------------
  // Delay timers
  // ---------------------------------------------------------------
  // A dropped condition restarts a timer, so noise never accumulates
  // Overcharge entry
  hold_timer #(.WIDTH(WIDTH)) oc_detect_timer (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .cond_in     (oc_detect_cond),
    .delay_in    (to_delay(OVERCHARGE_DETECT)),
    .expired_out (oc_detect_done)
  );

  // Overcharge release
  hold_timer #(.WIDTH(WIDTH)) oc_release_timer (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .cond_in     (oc_release_cond),
    .delay_in    (to_delay(OVERCHARGE_RELEASE)),
    .expired_out (oc_release_done)
  );

  // Overdischarge entry
  hold_timer #(.WIDTH(WIDTH)) od_detect_timer (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .cond_in     (od_detect_cond),
    .delay_in    (to_delay(OVERDISCHARGE_DETECT)),
    .expired_out (od_detect_done)
  );

  // Overdischarge release, from either state
  hold_timer #(.WIDTH(WIDTH)) od_release_timer (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .cond_in     (od_release_cond),
    .delay_in    (to_delay(OVERDISCHARGE_RELEASE)),
    .expired_out (od_release_done)
  );

  // Overcurrent level one
  hold_timer #(.WIDTH(WIDTH)) cur_one_timer (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .cond_in     (cur_one_cond),
    .delay_in    (to_delay(OVERCURRENT_ONE)),
    .expired_out (cur_one_done)
  );

  // Overcurrent level two, idle unless enabled
  hold_timer #(.WIDTH(WIDTH)) cur_two_timer (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .cond_in     (cur_two_cond),
    .delay_in    (to_delay(OVERCURRENT_TWO)),
    .expired_out (cur_two_done)
  );

  // Overcurrent release, shared by all options
  hold_timer #(.WIDTH(WIDTH)) cur_release_timer (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .cond_in     (cur_release_cond),
    .delay_in    (to_delay(OVERCURRENT_RELEASE)),
    .expired_out (cur_release_done)
  );

  // ---------------------------------------------------------------
  // State machines and drive
  // ---------------------------------------------------------------
  // Overdischarge has priority over overcurrent in the same cycle,
  // since a collapsing cell also stops any load current
  always_comb
  begin
    next_state      = state;
    // Two-stage synchronisers for comparators and straps
    next_state.meta     = compare_in;
    next_state.cmp      = state.meta;
    // Straps are meant to be static; a change mid-fault is not handled
    next_state.opt_meta = options_in;
    next_state.opt      = state.opt_meta;

    // Charge side
    if (!state.overcharge && oc_detect_done)
      next_state.overcharge = 1'b1;
    else if (state.overcharge && oc_release_done)
      next_state.overcharge = 1'b0;

    // Discharge side
    case (state.dis)
      // Overdischarge wins a tie with overcurrent
      DIS_NORMAL:
      begin
        if (od_detect_done)
          next_state.dis = DIS_OVERDIS;
        else if (cur_one_done || cur_two_done)
          next_state.dis = DIS_OVERCUR;
      end
      // Standby follows a charger at once, with no delay
      DIS_OVERDIS:
      begin
        if (od_release_done)
          next_state.dis = DIS_NORMAL;
        else if (state.cmp.sense_above_charger_detect)
          next_state.dis = DIS_STANDBY;
      end
      // Standby leaves only through the release timer
      DIS_STANDBY:
      begin
        if (od_release_done)
          next_state.dis = DIS_NORMAL;
      end
      // Same release path for auto and latched options
      DIS_OVERCUR:
      begin
        if (cur_release_done)
          next_state.dis = DIS_NORMAL;
      end
      default:
        next_state.dis = DIS_NORMAL;
    endcase

    // Gates are high when on; low turns the external switch off
    next_state.drive.charge_gate    = !next_state.overcharge;
    next_state.drive.discharge_gate = (next_state.dis == DIS_NORMAL);
    // Standby only signals; the low-power switch sits outside
    next_state.drive.standby        = (next_state.dis == DIS_STANDBY);
    // Pull-down only for auto release; latch waits for a charger
    next_state.drive.sense_pulldown = (next_state.dis == DIS_OVERCUR) &&
                                      !oc_latched(state.opt);
    next_state.drive.sense_pullup   = (next_state.dis == DIS_OVERCUR) &&
                                      oc_latched(state.opt);

    // Flags follow the next state, so they move with the gates
    next_state.overcharge_flag    = next_state.overcharge;
    next_state.overdischarge_flag = is_overdischarged(next_state.dis);
    next_state.overcurrent_flag   = (next_state.dis == DIS_OVERCUR);
  end

  // Reset: gates on, no pulls, all fault states clear
  // Straps read as auto release until the synchroniser fills
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state                      <= '0;
      state.drive.charge_gate    <= 1'b1;
      state.drive.discharge_gate <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs straight from flip-flops
  // ---------------------------------------------------------------
  assign charge_gate_out    = state.drive.charge_gate;
  assign discharge_gate_out = state.drive.discharge_gate;
  assign sense_pulldown_out = state.drive.sense_pulldown;
  assign sense_pullup_out   = state.drive.sense_pullup;
  assign standby_out        = state.drive.standby;
  assign overcharge_out     = state.overcharge_flag;
  assign overdischarge_out  = state.overdischarge_flag;
  assign overcurrent_out    = state.overcurrent_flag;

endmodule

// ### dv/cell_prot_monitor.sv
`timescale 1ns/1ns
// Ties each state output to the raw comparator history behind it
module cell_prot_monitor #(
  parameter int unsigned OVERCHARGE_DETECT    = 8,
  parameter int unsigned OVERCHARGE_RELEASE   = 6,
  parameter int unsigned OVERDISCHARGE_DETECT = 10,
  parameter int unsigned OVERCURRENT_ONE      = 20,
  parameter int unsigned OVERCURRENT_TWO      = 5,
  parameter int unsigned OVERCURRENT_RELEASE  = 9
) (
  // Clock and reset
  input wire logic                    core_clk_in,
  input wire logic                    nrst_in,
  // Inputs of the block
  input wire cell_prot_pkg::compare_t compare_in,
  input wire cell_prot_pkg::options_t options_in,
  // Outputs of the block
  input wire logic                    charge_gate_out,
  input wire logic                    discharge_gate_out,
  input wire logic                    sense_pulldown_out,
  input wire logic                    sense_pullup_out,
  input wire logic                    standby_out,
  input wire logic                    overcharge_out,
  input wire logic                    overdischarge_out,
  input wire logic                    overcurrent_out
);
  int unsigned run_ovc, run_ovd, run_one, run_two, run_rel, run_chr;
  logic        chr_ok;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // Release combinations the strap allows; raw levels lead the synchronised ones
  assign chr_ok = (compare_in.sense_above_charger_release && !compare_in.above_overcharge_detect) ||
                  (!options_in.overcharge_latch && compare_in.below_overcharge_release &&
                   !compare_in.sense_above_charger_release);
  // Unbroken hold counts of each raw condition
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      run_ovc <= 0;
      run_ovd <= 0;
      run_one <= 0;
      run_two <= 0;
      run_rel <= 0;
      run_chr <= 0;
    end
    else
    begin
      run_ovc <= compare_in.above_overcharge_detect ? run_ovc + 1 : 0;
      run_ovd <= compare_in.below_overdischarge_detect ? run_ovd + 1 : 0;
      run_one <= compare_in.above_oc_one ? run_one + 1 : 0;
      run_two <= compare_in.above_oc_two ? run_two + 1 : 0;
      run_rel <= compare_in.sense_below_oc_release ? run_rel + 1 : 0;
      run_chr <= chr_ok ? run_chr + 1 : 0;
    end
  end
  AST_CHG_GATE: assert property (charge_gate_out == !overcharge_out)
    else $error("charge gate wrong");
  AST_DIS_GATE: assert property (discharge_gate_out == !(overdischarge_out || overcurrent_out || standby_out))
    else $error("discharge gate wrong");
  AST_OVC_ENTRY: assert property ($rose(overcharge_out) |-> run_ovc >= OVERCHARGE_DETECT)
    else $error("overcharge entered early");
  AST_OVC_TIMELY: assert property (run_ovc == OVERCHARGE_DETECT + 8 |-> overcharge_out)
    else $error("overcharge entered late");
  AST_OVC_RELEASE: assert property ($fell(overcharge_out) |-> run_chr >= OVERCHARGE_RELEASE)
    else $error("overcharge released early");
  AST_OVD_ENTRY: assert property ($rose(overdischarge_out) |-> run_ovd >= OVERDISCHARGE_DETECT)
    else $error("overdischarge entered early");
  AST_OVD_TIMELY: assert property (run_ovd == OVERDISCHARGE_DETECT + 8 && !overcurrent_out |->
    overdischarge_out || standby_out) else $error("overdischarge entered late");
  AST_CUR_ENTRY: assert property ($rose(overcurrent_out) |-> run_one >= OVERCURRENT_ONE ||
    (options_in.oc_two_enable && run_two >= OVERCURRENT_TWO)) else $error("overcurrent entered early");
  AST_CUR_RELEASE: assert property ($fell(overcurrent_out) |-> run_rel >= OVERCURRENT_RELEASE)
    else $error("overcurrent released early");
  AST_PULLDOWN: assert property (sense_pulldown_out ==
    (overcurrent_out && options_in.oc_release != cell_prot_pkg::OC_LATCH)) else $error("pulldown wrong");
  AST_PULLUP: assert property (sense_pullup_out ==
    (overcurrent_out && options_in.oc_release == cell_prot_pkg::OC_LATCH)) else $error("pullup wrong");
  AST_STANDBY: assert property ($rose(standby_out) |->
    $past(overdischarge_out) && $past(compare_in.sense_above_charger_detect)) else $error("standby wrong");
  COV_STANDBY: cover property ($rose(standby_out));
  COV_LATCHED: cover property (overcurrent_out && sense_pullup_out);
  COV_OVC_REL: cover property ($fell(overcharge_out));
endmodule
bind cell_protection_state_logic cell_prot_monitor #(
  .OVERCHARGE_DETECT(OVERCHARGE_DETECT), .OVERCHARGE_RELEASE(OVERCHARGE_RELEASE),
  .OVERDISCHARGE_DETECT(OVERDISCHARGE_DETECT), .OVERCURRENT_ONE(OVERCURRENT_ONE),
  .OVERCURRENT_TWO(OVERCURRENT_TWO), .OVERCURRENT_RELEASE(OVERCURRENT_RELEASE)
) mon (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .compare_in(compare_in), .options_in(options_in),
  .charge_gate_out(charge_gate_out), .discharge_gate_out(discharge_gate_out),
  .sense_pulldown_out(sense_pulldown_out), .sense_pullup_out(sense_pullup_out), .standby_out(standby_out),
  .overcharge_out(overcharge_out), .overdischarge_out(overdischarge_out), .overcurrent_out(overcurrent_out)
);

// ### dv/cell_front_model.sv
`timescale 1ns/1ns
// Comparator bank and sense node as seen from the pack
module cell_front_model #(
  parameter int OVC_DET = 4300,
  parameter int OVC_REL = 4100,
  parameter int OVD_DET = 2500,
  parameter int OVD_REL = 2900,
  parameter int CHG_REL = 100,
  parameter int CHG_DET = 800,
  parameter int CUR_REL = 700,
  parameter int CUR_ONE = 20,
  parameter int CUR_TWO = 50
) (
  // Clock and pull controls
  input  wire logic               core_clk_in,
  input  wire logic               pulldown_in,
  input  wire logic               pullup_in,
  // Pack voltages in millivolts
  input  wire logic               ext_on_in,
  input  wire logic signed [15:0] ext_mv_in,
  input  wire logic signed [15:0] cell_mv_in,
  input  wire logic signed [15:0] shunt_mv_in,
  // Comparator levels
  output cell_prot_pkg::compare_t compare_out
);
  logic               flip = 1'b0;
  logic signed [15:0] sense;
  // A bare node wanders so that a stale level never passes for a real one
  always_ff @(posedge core_clk_in)
    flip <= !flip;
  // External drive wins over the weak internal pulls
  always_comb
  begin
    if (ext_on_in)
      sense = ext_mv_in;
    else if (pullup_in)
      sense = cell_mv_in;
    else if (pulldown_in)
      sense = 16'sh0000;
    else
      sense = flip ? cell_mv_in : 16'sh0000;
  end
  // Comparators, in struct order
  assign compare_out = '{cell_mv_in > OVC_DET, cell_mv_in < OVC_REL, cell_mv_in < OVD_DET, cell_mv_in > OVD_REL,
    sense > CHG_REL, sense > CHG_DET, sense < CUR_REL, shunt_mv_in > CUR_ONE, shunt_mv_in > CUR_TWO};
endmodule

// ### dv/cell_protection_state_logic_tb.sv
`timescale 1ns/1ns
module cell_protection_state_logic_tb;
  localparam int OCD = 8, OCR = 6, ODD = 10, ODR = 7, C1 = 20, C2 = 5, CR = 9;
  localparam int CG = 7, DG = 6, PD = 5, PU = 4, SB = 3, OC = 2, OD = 1, CU = 0;
  logic                    core_clk, nrst, ext_on;
  logic signed [15:0]      cell_mv, ext_mv, shunt_mv;
  cell_prot_pkg::compare_t cmp;
  cell_prot_pkg::options_t opts;
  wire [7:0]               flags;
  int                      failures, cmp_count, d;
  cell_front_model fe (.core_clk_in(core_clk), .pulldown_in(flags[PD]), .pullup_in(flags[PU]), .ext_on_in(ext_on),
    .ext_mv_in(ext_mv), .cell_mv_in(cell_mv), .shunt_mv_in(shunt_mv), .compare_out(cmp));
  cell_protection_state_logic #(.OVERCHARGE_DETECT(OCD), .OVERCHARGE_RELEASE(OCR), .OVERDISCHARGE_DETECT(ODD),
    .OVERDISCHARGE_RELEASE(ODR), .OVERCURRENT_ONE(C1), .OVERCURRENT_TWO(C2), .OVERCURRENT_RELEASE(CR)) dut (
    .core_clk_in(core_clk), .nrst_in(nrst), .compare_in(cmp), .options_in(opts),
    .charge_gate_out(flags[CG]), .discharge_gate_out(flags[DG]), .sense_pulldown_out(flags[PD]),
    .sense_pullup_out(flags[PU]), .standby_out(flags[SB]), .overcharge_out(flags[OC]),
    .overdischarge_out(flags[OD]), .overcurrent_out(flags[CU]));
  task automatic close_out();
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", name, exp, got);
    end
  endtask
  // Pack conditions, applied at the falling edge
  task automatic drive(input int c, input logic e_on, input int e, input int s);
    cell_mv = 16'(c);
    ext_on = e_on;
    ext_mv = 16'(e);
    shunt_mv = 16'(s);
  endtask
  // Flag must take val after more than lo and at most hi cycles
  task automatic wait_flag(input string name, input int idx, input logic val, input int lo, input int hi);
    int n;
    n = 0;
    while (flags[idx] !== val && n < hi)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(name, 1'b1, flags[idx] === val && n > lo);
  endtask
  task automatic hold_flag(input string name, input int idx, input logic val, input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      chk(name, val, flags[idx]);
    end
  endtask
  // Free-running clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, far beyond the few hundred cycles of the run
  initial
  begin
    #200000;
    failures++;
    close_out();
  end
  // Three strap sets: auto one, auto two without level two, all latched
  initial
  begin
    failures = 0;
    cmp_count = 0;
    for (int ph = 0; ph < 3; ph++)
    begin
      opts = '{ph == 2, ph == 2, ph != 1, cell_prot_pkg::oc_release_t'(ph)};
      drive(3700, 1'b1, 0, 0);
      nrst = 1'b0;
      repeat (2) @(negedge core_clk);
      nrst = 1'b1;
      chk("reset flags", 1'b1, flags === 8'hc0);
      if (ph == 0)
      begin
        drive(4400, 1'b1, 0, 0);
        repeat (OCD - 2) @(negedge core_clk);
        drive(4200, 1'b1, 0, 0);
        repeat (2) @(negedge core_clk);
        for (int k = 0; k < 2; k++)
        begin
          drive(4400, 1'b1, 500, 0);
          wait_flag("overcharge entry", OC, 1'b1, OCD, OCD + 8);
          chk("charge gate", 1'b0, flags[CG]);
          drive(k ? 4200 : 4000, 1'b1, k ? 500 : 0, 0);
          wait_flag("overcharge release", OC, 1'b0, OCR, OCR + 8);
        end
        drive(2400, 1'b1, 0, 0);
        wait_flag("overdischarge entry", OD, 1'b1, ODD, ODD + 8);
        chk("discharge gate", 1'b0, flags[DG]);
        drive(2600, 1'b1, 0, 0);
        wait_flag("overdischarge release", OD, 1'b0, ODR, ODR + 8);
        drive(2400, 1'b1, 0, 0);
        wait_flag("overdischarge entry", OD, 1'b1, ODD, ODD + 8);
        drive(2400, 1'b1, 3000, 0);
        wait_flag("standby entry", SB, 1'b1, 0, 5);
        drive(3000, 1'b1, 3000, 0);
        wait_flag("standby release", DG, 1'b1, ODR, ODR + 8);
      end
      d = (ph == 1) ? C1 : C2;
      drive(3700, 1'b1, 1000, 60);
      wait_flag("overcurrent entry", CU, 1'b1, d, d + 8);
      chk("discharge gate", 1'b0, flags[DG]);
      chk("pulldown", ph != 2, flags[PD]);
      chk("pullup", ph == 2, flags[PU]);
      drive(3700, 1'b0, 0, 0);
      if (ph == 2)
      begin
        hold_flag("latched overcurrent", CU, 1'b1, 3 * CR);
        drive(3700, 1'b1, -200, 0);
      end
      wait_flag("overcurrent release", CU, 1'b0, CR, CR + 8);
      chk("discharge gate", 1'b1, flags[DG]);
      if (ph == 2)
      begin
        drive(4400, 1'b1, 0, 0);
        wait_flag("overcharge entry", OC, 1'b1, OCD, OCD + 8);
        drive(4000, 1'b1, 0, 0);
        hold_flag("latched overcharge", OC, 1'b1, 3 * OCR);
        drive(4200, 1'b1, 500, 0);
        wait_flag("overcharge release", OC, 1'b0, OCR, OCR + 8);
        drive(2400, 1'b1, 3000, 0);
        wait_flag("overdischarge entry", DG, 1'b0, ODD, ODD + 8);
        drive(3000, 1'b1, 3000, 0);
        hold_flag("latched standby", DG, 1'b0, 3 * ODR);
        drive(3000, 1'b1, 0, 0);
        wait_flag("latched release", DG, 1'b1, ODR, ODR + 8);
      end
    end
    close_out();
  end
endmodule
